/* File: rtl/dsw_chan.sv */
// Purpose: One channel's register set and field decode.
// Assumes: Write strobes are one-cycle pulses from the frame decoder.
// Notes: Instantiated once per bank.
`timescale 1ns/10ps
module dsw_chan
    import dsw_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Write side.
    input wire logic wr_duty,
    input wire logic wr_config,
    input wire logic wr_overcurrent,
    input wire logic [8:0] wr_data,
    // Channel context.
    input wire logic load_type_pin,
    input wire logic window_active,
    // Register contents and decode.
    output logic [8:0] duty_cycle_control,
    output logic [8:0] channel_configuration,
    output logic [8:0] overcurrent_configuration,
    output dsw_chan_t ctl
);
    // Register storage, cleared on reset.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_cycle_control <= FIELD_RESET;
            channel_configuration <= FIELD_RESET;
            overcurrent_configuration <= FIELD_RESET;
        end else begin
            if (wr_duty) begin
                duty_cycle_control <= wr_data;
            end
            if (wr_config) begin
                channel_configuration <= wr_data;
            end
            if (wr_overcurrent) begin
                overcurrent_configuration <= wr_data;
            end
        end
    end

    // Field decode into channel controls.
    always_comb begin
        ctl.duty_enable = duty_cycle_control[8];
        ctl.duty_level = duty_cycle_control[7:0];
        ctl.supply_short_detect_off = channel_configuration[8];
        ctl.open_load_on_detect_off = channel_configuration[7];
        ctl.open_load_off_detect_off = channel_configuration[6];
        ctl.direct_control_off = channel_configuration[5];
        ctl.edge_rate = dsw_rate_t'(channel_configuration[4:3]);
        ctl.turn_on_delay = channel_configuration[2:0];
        if (!overcurrent_configuration[8]) begin
            ctl.lower_limit_level = DSW_OCL_HIGHEST;
        end else if (overcurrent_configuration[0]) begin
            ctl.lower_limit_level = DSW_OCL_LOWEST;
        end else begin
            ctl.lower_limit_level = DSW_OCL_MEDIUM;
        end
        ctl.ext_clock_divide = overcurrent_configuration[7] ?
            DIV_HI_COUNT : DIV_LO_COUNT;
        ctl.internal_clock = overcurrent_configuration[6];
        ctl.sense_ratio_select = overcurrent_configuration[5];
        ctl.upper_limit_select = overcurrent_configuration[2];
        ctl.middle_limit_used = !load_type_pin;
        ctl.middle_limit_select = overcurrent_configuration[1] &&
            !load_type_pin;
        ctl.window_single = load_type_pin;
        ctl.window_code = overcurrent_configuration[4:3];
        ctl.sense_allowed = !window_active;
    end
endmodule

/* File: rtl/dsw_pkg.sv */
// Purpose: Shared constants and types for the dual switch SPI config bank.
// Assumes: 16-bit serial words, one system clock.
// Notes: Bank select and address codes sit in the upper bits of each word.
package dsw_pkg;
    localparam int WORD_BITS = 16;
    localparam int FIELD_BITS = 9;
    localparam int BANK_BIT = 13;
    localparam int ADDR_HI = 12;
    localparam int ADDR_LO = 10;
    localparam int PWM_DIV_LO = 256;
    localparam int PWM_DIV_HI = 512;
    localparam logic [2:0] ADDR_READBACK = 3'h0;
    localparam logic [2:0] ADDR_DUTY = 3'h1;
    localparam logic [2:0] ADDR_CONFIG = 3'h2;
    localparam logic [2:0] ADDR_OVERCURRENT = 3'h4;
    localparam logic [8:0] FIELD_RESET = 9'h000;
    localparam logic [2:0] SEL_RESET = 3'h0;
    // Readback codes of the channel registers on the serial output side.
    localparam logic [2:0] SEL_DUTY = 3'h2;
    localparam logic [2:0] SEL_CONFIG = 3'h3;
    localparam logic [2:0] SEL_OVERCURRENT = 3'h4;
    localparam logic [9:0] DIV_LO_COUNT = 10'h100;
    localparam logic [9:0] DIV_HI_COUNT = 10'h200;

    typedef enum logic [1:0] {
        DSW_RATE_MEDIUM,
        DSW_RATE_LOW,
        DSW_RATE_HIGH,
        DSW_RATE_MED_HIGH
    } dsw_rate_t;

    typedef enum logic [1:0] {
        DSW_OCL_HIGHEST,
        DSW_OCL_MEDIUM,
        DSW_OCL_LOWEST
    } dsw_ocl_t;

    // Decoded controls of one channel.
    typedef struct packed {
        logic duty_enable;
        logic [7:0] duty_level;
        logic supply_short_detect_off;
        logic open_load_on_detect_off;
        logic open_load_off_detect_off;
        logic direct_control_off;
        dsw_rate_t edge_rate;
        logic [2:0] turn_on_delay;
        dsw_ocl_t lower_limit_level;
        logic [9:0] ext_clock_divide;
        logic internal_clock;
        logic sense_ratio_select;
        logic upper_limit_select;
        logic middle_limit_select;
        logic middle_limit_used;
        logic window_single;
        logic [1:0] window_code;
        logic sense_allowed;
    } dsw_chan_t;
endpackage

/* File: rtl/dsw_regs.sv */
// Purpose: Serial input word decode for two banks of channel registers.
// Assumes: The serial front end delivers each complete 16-bit word with a
//          one-cycle strobe; the master addresses bits 13 to 10 correctly.
// Notes: Readback selection takes effect for the next transfer.
//
// Overview of operation
// - Word bits 13..10 carry the register address; device decodes them.
// - Bit 13 selects bank: zero channel zero (default), one channel one.
// - Status-select write names an output register in bits 2..0 for readback.
// - Duty register: bit 8 enables, bits 7..0 pick one of 256 levels.
// - Configuration bit 8 high disables supply short detection.
// - Configuration bit 7 high disables on-state open-load detection.
// - Configuration bit 6 high disables off-state open-load detection.
// - Configuration bit 5 high ignores direct input control.
// - Bits 4..3 select edge rate: medium, low, high, medium-high.
// - Bits 2..0 delay turn-on by that many clock periods.
// - Overcurrent bit 8 and bit 0 pick the lower threshold level.
// - No current sense output while an overcurrent window runs.
// - Overcurrent bit 7 picks external prescaler 512 or 256.
// - Overcurrent bit 6 high selects the internal pulse clock.
// - Overcurrent bit 5 high selects low-current sense ratio.
// - Lighting uses three thresholds; motor uses upper and lower only.
// - Bits 4 and 3 choose window lengths, by load type.
// - Overcurrent bit 2 selects upper threshold value.
// - Overcurrent bit 1 selects middle threshold; ignored for motor.
// - Addressed readback data appears in the following transfer.
`timescale 1ns/10ps
module dsw_regs
    import dsw_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Received serial word.
    input wire logic frame_done,
    input wire logic [15:0] frame_word,
    // Load type of each channel and overcurrent window state.
    input wire logic [1:0] load_type_pin,
    input wire logic [1:0] window_active,
    // Readback selection for the next transfer.
    output logic readback_bank,
    output logic [2:0] readback_select,
    output logic readback_valid,
    output logic [8:0] readback_data,
    // Channel zero controls.
    output dsw_chan_t chan0_ctl,
    // Channel one controls.
    output dsw_chan_t chan1_ctl,
    // Current sense output gating per channel.
    output logic [1:0] current_sense_output_en
);
    logic rst_meta;
    logic rst_n;
    logic bank_select;
    logic [2:0] addr_code;
    logic [1:0] wr_duty;
    logic [1:0] wr_config;
    logic [1:0] wr_overcurrent;
    logic [8:0] duty_q [2];
    logic [8:0] load_type_pin_q [2];
    logic [8:0] ovc_q [2];
    dsw_chan_t ctl_c [2];
    logic [8:0] next_readback;

    // Reset release through two flip-flops.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Address and bank fields of the completed word.
    assign bank_select = frame_word[BANK_BIT];
    assign addr_code = frame_word[ADDR_HI:ADDR_LO];

    // Per-bank write strobes, only on a completed frame.
    always_comb begin
        wr_duty = 2'h0;
        wr_config = 2'h0;
        wr_overcurrent = 2'h0;
        if (frame_done) begin
            unique case (addr_code)
                ADDR_DUTY: wr_duty[bank_select] = 1'b1;
                ADDR_CONFIG: wr_config[bank_select] = 1'b1;
                ADDR_OVERCURRENT: wr_overcurrent[bank_select] = 1'b1;
                default: begin
                end
            endcase
        end
    end

    // One register set per bank.
    for (genvar i = 0; i < 2; i++) begin : g_bank
        dsw_chan u_chan (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .wr_duty(wr_duty[i]),
            .wr_config(wr_config[i]),
            .wr_overcurrent(wr_overcurrent[i]),
            .wr_data(frame_word[8:0]),
            .load_type_pin(load_type_pin[i]),
            .window_active(window_active[i]),
            .duty_cycle_control(duty_q[i]),
            .channel_configuration(load_type_pin_q[i]),
            .overcurrent_configuration(ovc_q[i]),
            .ctl(ctl_c[i])
        );
    end

    // Readback selection latched from a status-select word.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            readback_bank <= 1'b0;
            readback_select <= SEL_RESET;
        end else if (frame_done && addr_code == ADDR_READBACK) begin
            readback_bank <= bank_select;
            readback_select <= frame_word[2:0];
        end
    end

    // Contents of the selected bank register, from current state.
    // Duty and configuration readback codes differ from their write addresses: the output side
    // numbers its registers with the fault report at code one.
    always_comb begin
        next_readback = FIELD_RESET;
        unique case (readback_select)
            SEL_DUTY: next_readback = duty_q[readback_bank];
            SEL_CONFIG: next_readback = load_type_pin_q[readback_bank];
            SEL_OVERCURRENT: next_readback = ovc_q[readback_bank];
            default: next_readback = FIELD_RESET;
        endcase
    end

    // Readback word registered, valid from the selecting frame until the next frame.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            readback_data <= FIELD_RESET;
            readback_valid <= 1'b0;
        end else begin
            readback_data <= next_readback;
            if (frame_done) begin
                readback_valid <= addr_code == ADDR_READBACK;
            end
        end
    end

    // Registered channel controls and sense gating.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan0_ctl <= '0;
            chan1_ctl <= '0;
            current_sense_output_en <= 2'h0;
        end else begin
            chan0_ctl <= ctl_c[0];
            chan1_ctl <= ctl_c[1];
            current_sense_output_en <= {ctl_c[1].sense_allowed,
                ctl_c[0].sense_allowed};
        end
    end
endmodule

/* File: test/dsw_master.sv */
// Purpose: Far-side master model delivering whole words.
// Assumes: The bench pulses send once per word.
// Notes: Idle word lines toggle so stale data cannot pass.
`timescale 1ns/10ps
module dsw_master (
    // Request from the bench.
    input wire logic sys_clk,
    input wire logic send,
    input wire logic [15:0] word,
    // Completed frame.
    output logic frame_done = 1'b0,
    output logic [15:0] frame_word = 16'h0000
);
    // One full word per request, inverted stale word otherwise.
    always @(posedge sys_clk) begin
        frame_done <= send;
        frame_word <= send ? word : ~frame_word;
    end
endmodule

/* File: test/dsw_regs_props.sv */
// Purpose: Port assertions for the config bank.
// Assumes: Decoded fields land two edges after their frame.
// Notes: Checks wait until the internal reset copy has settled.
`timescale 1ns/10ps
module dsw_regs_props
    import dsw_pkg::*;
(
    // Clock, reset and inputs.
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic frame_done,
    input wire logic [15:0] frame_word,
    input wire logic [1:0] window_active,
    input wire logic [1:0] load_type_pin,
    // Outputs.
    input wire logic readback_bank,
    input wire logic [2:0] readback_select,
    input wire dsw_chan_t chan0_ctl,
    input wire dsw_chan_t chan1_ctl,
    input wire logic [1:0] current_sense_output_en
);
    logic [2:0] up;
    logic ok, f, dty, cfg, ocr;
    logic [8:0] d;
    // Counts edges after release.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) up <= 3'h0;
        else if (!ok) up <= up + 3'h1;
    end
    // Qualified frames by bank and address.
    assign ok = (up == 3'h7);
    assign f = ok && frame_done;
    assign d = frame_word[8:0];
    assign dty = f && frame_word[13:10] == 4'h1;
    assign cfg = f && frame_word[13:10] == 4'hA;
    assign ocr = f && frame_word[13:10] == 4'h4;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Struct bits 38:30 hold duty, 29:21 the configuration fields.
    a_duty_load: assert property (dty
        |=> ##1 chan0_ctl[38:30] == $past(d, 2)) else $error("duty decode");
    a_cfg_load: assert property (cfg
        |=> ##1 chan1_ctl[29:21] == $past(d, 2)) else $error("config decode");
    a_ocr_clock: assert property (ocr |=> ##1 chan0_ctl[18:8] ==
        {($past(d[7], 2) ? DIV_HI_COUNT : DIV_LO_COUNT), $past(d[6], 2)})
        else $error("clock decode");
    a_ocr_limits: assert property (ocr |=> ##1 chan0_ctl[7:5] ==
        {$past(d[5], 2), $past(d[2], 2),
        $past(d[1] && !load_type_pin[0], 2)}) else $error("limit decode");
    a_motor_middle: assert property (ok && load_type_pin[1]
        |=> !chan1_ctl.middle_limit_select) else $error("motor middle used");
    a_low_level: assert property (ocr |=> ##1
        chan0_ctl.lower_limit_level == (!$past(d[8], 2) ? DSW_OCL_HIGHEST :
        $past(d[0], 2) ? DSW_OCL_LOWEST : DSW_OCL_MEDIUM))
        else $error("lower level decode");
    a_read_pick: assert property (f && frame_word[12:10] == 3'h0
        |=> readback_bank == $past(frame_word[13]) &&
        readback_select == $past(frame_word[2:0])) else $error("readback");
    a_bank_hold: assert property (f && frame_word[13]
        |=> ##1 $stable(chan0_ctl[38:30])) else $error("bank zero changed");
    a_sense_off: assert property (ok && window_active[0]
        |=> !current_sense_output_en[0]) else $error("sense not gated");
endmodule

/* File: test/test_dsw_regs.sv */
// Purpose: Self-checking bench for the config bank.
// Assumes: Words reach the bank through the master model.
// Notes: Outputs are judged four edges after each frame.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("Error t=%0t %h %h", $time, (a), (b)); end end
module test_dsw_regs
    import dsw_pkg::*;
;
    logic sys_clk, rst_b = 1'b0, send = 1'b0, frame_done;
    logic readback_bank, readback_valid;
    logic [15:0] word = 16'h0000, frame_word;
    logic [1:0] load_type_pin = 2'h0, window_active = 2'h0;
    logic [1:0] current_sense_output_en, k;
    logic [2:0] readback_select;
    logic [8:0] readback_data, d;
    dsw_chan_t chan0_ctl, chan1_ctl;
    int failures = 0, checked = 0, cycles = 0;
    // Master model and the bank.
    dsw_master dsw_master_inst (.sys_clk, .send, .word, .frame_done,
        .frame_word);
    dsw_regs dsw_regs_inst (.sys_clk, .rst_b, .frame_done, .frame_word,
        .load_type_pin, .window_active, .readback_bank, .readback_select,
        .readback_valid, .readback_data, .chan0_ctl, .chan1_ctl,
        .current_sense_output_en);
    // Clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Hang guard.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            end_sim();
        end
    end
    // Hands one word over and lets the decode land.
    task automatic put(input logic [15:0] w);
        @(posedge sys_clk);
        send <= 1'b1;
        word <= w;
        @(posedge sys_clk);
        send <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    // Reset values, both duty banks and two unmapped addresses.
    task automatic t_duty();
        `CHK(chan0_ctl.duty_level, 8'h00)
        `CHK(chan1_ctl.ext_clock_divide, DIV_LO_COUNT)
        put(16'h07FF);
        put(16'h24AA);
        put(16'h0C55);
        put(16'h1980);
        `CHK({chan0_ctl.duty_enable, chan0_ctl.duty_level}, 9'h1FF)
        `CHK({chan1_ctl.duty_enable, chan1_ctl.duty_level}, 9'h0AA)
        `CHK(chan0_ctl.turn_on_delay, 3'h0)
        $display("t_duty done");
    endtask
    // Every edge rate in bank one, then read it back.
    task automatic t_config();
        for (int i = 0; i < 4; i++) begin
            d = {4'(4'h1 << i), 2'(i), 3'(i + 1)};
            put(16'h2800 | 16'(d));
            `CHK(chan1_ctl[29:26], d[8:5])
            `CHK(2'(chan1_ctl.edge_rate), d[4:3])
            `CHK(chan1_ctl.turn_on_delay, d[2:0])
        end
        put(16'h2002);
        `CHK({readback_valid, readback_bank, readback_select}, 5'h1A)
        `CHK(readback_data, 9'h0AA)
        put(16'h2003);
        `CHK({readback_valid, readback_bank, readback_select}, 5'h1B)
        `CHK(readback_data, d)
        $display("t_config done");
    endtask
    // All lower level codes, with clock and limit bits tied to them.
    task automatic t_ocr();
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            d = {k[1], k[0], k[1], ~k[0], k[1], k[0], k[1], k[0], k[0]};
            put(16'h1000 | 16'(d));
            `CHK(chan0_ctl.lower_limit_level, !k[1] ? DSW_OCL_HIGHEST :
                k[0] ? DSW_OCL_LOWEST : DSW_OCL_MEDIUM)
            `CHK(chan0_ctl[18:7], {k[0] ? DIV_HI_COUNT : DIV_LO_COUNT,
                k[1], ~k[0]})
            `CHK(chan0_ctl[6:5], k)
            `CHK(chan0_ctl.window_code, k)
        end
        $display("t_ocr done");
    endtask
    // Motor load on channel one, overcurrent window on channel zero.
    task automatic t_load();
        @(posedge sys_clk);
        load_type_pin <= 2'b10;
        window_active <= 2'b01;
        put(16'h3C00);
        `CHK({chan0_ctl.middle_limit_used, chan1_ctl[4:3]}, 3'h5)
        `CHK(current_sense_output_en, 2'b10)
        @(posedge sys_clk);
        window_active <= 2'b00;
        put(16'h1C00);
        `CHK(current_sense_output_en, 2'b11)
        put(16'h3002);
        `CHK(chan1_ctl[6:5], 2'b00)
        $display("t_load done");
    endtask
    // Prints the counts and the verdict.
    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        t_duty();
        t_config();
        t_ocr();
        t_load();
        end_sim();
    end
endmodule
bind dsw_regs dsw_regs_props dsw_regs_props_inst (.sys_clk, .rst_b,
    .frame_done, .frame_word, .window_active, .load_type_pin, .readback_bank,
    .readback_select, .chan0_ctl, .chan1_ctl, .current_sense_output_en);
